// File: rtl/cpr_regfile.sv
// Banked CPU register file with Avalon-MM register access
`timescale 1ns/1ns
// Notes on behaviour
// - Instruction pointer 16 bits, resets to fffd
// - Main accumulator 16 bits, low byte view
// - Auxiliary accumulator 16 bits, low byte view
// - Index register 16 bits supplies addressing offset
// - Extra pointer used directly as address
// - Stack pointer 16 bits locates stack
// - Status word halves: bank select, flags
// - Reset clears top flag, sets levels 11
// - General registers 8 bits in data memory
// - Eight registers per bank, 32 banks
// - Bank select field picks active bank
module cpr_regfile
    import cpr_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    // Avalon-MM slave
    input  wire logic [CPR_ADDR_W-1:0] i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [CPR_BE_W-1:0]   i_avs_byteenable,
    input  wire logic [CPR_DATA_W-1:0] i_avs_writedata,
    output logic      [CPR_DATA_W-1:0] o_avs_readdata,
    output logic                       o_avs_waitrequest,
    // Core access to general registers of the active bank
    input  wire logic [CPR_SEL_W-1:0]  i_gpr_sel,
    input  wire logic                  i_gpr_we,
    input  wire logic [7:0]            i_gpr_wdata,
    output logic      [7:0]            o_gpr_rdata,
    output logic      [7:0]            o_gpr_mem_addr,
    // Dedicated register views
    output logic      [15:0]           o_instruction_pointer,
    output logic      [7:0]            o_acc_byte,
    output logic      [7:0]            o_aux_byte,
    output logic      [15:0]           o_index_offset,
    output logic      [15:0]           o_extra_addr,
    output logic      [15:0]           o_stack_addr,
    output logic      [7:0]            o_bank_select,
    output logic      [7:0]            o_condition_flags
);

    // ==========================================================
    // Bus handshake
    // ==========================================================
    cpr_bus_st_t         st_reg;
    cpr_bus_st_t         st_next;
    logic                req;
    logic                accept;
    logic                wr_acc;
    logic [31:0]         rdata_reg;
    logic [31:0]         rdata_next;

    // One wait cycle, then the request is accepted
    assign req               = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = req && (st_reg != CPR_ST_ACK);
    assign accept            = req && (st_reg == CPR_ST_ACK);
    assign wr_acc            = accept && i_avs_write;

    // Next state of the handshake
    always_comb begin
        case (st_reg)
            CPR_ST_IDLE: st_next = req ? CPR_ST_ACK : CPR_ST_IDLE;
            CPR_ST_ACK:  st_next = CPR_ST_IDLE;
            default:     st_next = CPR_ST_IDLE;
        endcase
    end

    // Handshake state and read data capture
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            st_reg    <= CPR_ST_IDLE;
            rdata_reg <= 32'h0000_0000;
        end else begin
            st_reg    <= st_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_avs_readdata = rdata_reg;

    // ==========================================================
    // Address decode
    // ==========================================================
    logic        hit_ip;
    logic        hit_acc;
    logic        hit_aux;
    logic        hit_idx;
    logic        hit_xptr;
    logic        hit_stk;
    logic        hit_psw;
    logic        hit_bank;
    logic        hit_gpr;
    logic [1:0]  be16;
    logic [7:0]  bus_gpr_idx;

    assign hit_ip      = (i_avs_address == CPR_OFF_IP);
    assign hit_acc     = (i_avs_address == CPR_OFF_ACC);
    assign hit_aux     = (i_avs_address == CPR_OFF_AUX);
    assign hit_idx     = (i_avs_address == CPR_OFF_IDX);
    assign hit_xptr    = (i_avs_address == CPR_OFF_XPTR);
    assign hit_stk     = (i_avs_address == CPR_OFF_STK);
    assign hit_psw     = (i_avs_address == CPR_OFF_PSW);
    assign hit_bank    = (i_avs_address == CPR_OFF_BANKSEL);
    assign hit_gpr     = (i_avs_address[11:10] == CPR_GPR_REGION) &&
                         (i_avs_address[1:0] == 2'h0);
    assign be16        = i_avs_byteenable[1:0];
    assign bus_gpr_idx = i_avs_address[9:2];

    // ==========================================================
    // Dedicated registers
    // ==========================================================
    logic [15:0] ip_q;
    logic [15:0] acc_q;
    logic [15:0] aux_q;
    logic [15:0] idx_q;
    logic [15:0] xptr_q;
    logic [15:0] stk_q;
    logic [15:0] psw_reg;
    logic [15:0] psw_next;

    cpr_reg16 #(.HAS_RESET(1'b1), .RESET_VAL(CPR_IP_RESET)) u_ip (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_ip),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (ip_q)
    );

    cpr_reg16 u_acc (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_acc),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (acc_q)
    );

    cpr_reg16 u_aux (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_aux),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (aux_q)
    );

    cpr_reg16 u_idx (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_idx),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (idx_q)
    );

    cpr_reg16 u_xptr (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_xptr),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (xptr_q)
    );

    cpr_reg16 u_stk (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_we      (wr_acc && hit_stk),
        .i_be      (be16),
        .i_wdata   (i_avs_writedata[15:0]),
        .o_q       (stk_q)
    );

    // status word written per byte lane, or as bank byte alone through its own offset
    assign psw_next = {(wr_acc && ((hit_psw && be16[1]) || (hit_bank && be16[0])))
                           ? (hit_bank ? i_avs_writedata[7:0] : i_avs_writedata[15:8])
                           : psw_reg[15:8],
                       (wr_acc && hit_psw && be16[0]) ? i_avs_writedata[7:0]
                           : psw_reg[7:0]};

    // top flag cleared, level bits set at reset
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            psw_reg <= CPR_PSW_RESET;
        end else begin
            psw_reg <= psw_next;
        end
    end

    // ==========================================================
    // General-purpose register banks
    // ==========================================================
    logic [CPR_BANK_W-1:0] bank_sel;
    logic [7:0]            core_idx;
    logic                  gpr_we;
    logic [7:0]            gpr_waddr;
    logic [7:0]            gpr_wdata;
    logic [7:0]            bus_gpr_rdata;
    logic                  bus_gpr_wr;

    // active bank from the bank select field
    assign bank_sel = psw_reg[CPR_PSW_BANK_LSB +: CPR_BANK_W];
    // eight registers per bank, bank in upper bits
    assign core_idx = {bank_sel, i_gpr_sel};

    // Core write wins; a clashing bus write is dropped
    assign bus_gpr_wr = wr_acc && hit_gpr && i_avs_byteenable[0];
    assign gpr_we     = i_gpr_we || bus_gpr_wr;
    assign gpr_waddr  = i_gpr_we ? core_idx : bus_gpr_idx;
    assign gpr_wdata  = i_gpr_we ? i_gpr_wdata : i_avs_writedata[7:0];

    // byte-wide registers in a memory array
    cpr_gpr_bank #(
        .DEPTH  (CPR_NUM_BANKS * CPR_REGS_PER_BANK),
        .ADDR_W (8)
    ) u_gpr (
        .i_ref_clk (i_ref_clk),
        .i_we      (gpr_we),
        .i_waddr   (gpr_waddr),
        .i_wdata   (gpr_wdata),
        .i_raddr_a (core_idx),
        .i_raddr_b (bus_gpr_idx),
        .o_rdata_a (o_gpr_rdata),
        .o_rdata_b (bus_gpr_rdata)
    );

    assign o_gpr_mem_addr = core_idx;

    // ==========================================================
    // Read data select
    // ==========================================================
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (i_avs_read && (st_reg == CPR_ST_IDLE)) begin
            if (hit_ip) begin
                rdata_next = {16'h0000, ip_q};
            end else if (hit_acc) begin
                rdata_next = {16'h0000, acc_q};
            end else if (hit_aux) begin
                rdata_next = {16'h0000, aux_q};
            end else if (hit_idx) begin
                rdata_next = {16'h0000, idx_q};
            end else if (hit_xptr) begin
                rdata_next = {16'h0000, xptr_q};
            end else if (hit_stk) begin
                rdata_next = {16'h0000, stk_q};
            end else if (hit_psw) begin
                rdata_next = {16'h0000, psw_reg};
            end else if (hit_bank) begin
                rdata_next = {24'h00_0000, psw_reg[15:8]};
            end else if (hit_gpr) begin
                rdata_next = {24'h00_0000, bus_gpr_rdata};
            end
        end else if (st_reg == CPR_ST_ACK) begin
            rdata_next = rdata_reg;     // Hold for the accepting edge
        end
    end

    // ==========================================================
    // Register views to the core
    // ==========================================================
    assign o_instruction_pointer = ip_q;
    // 8-bit operations see the low byte
    assign o_acc_byte            = acc_q[7:0];
    assign o_aux_byte            = aux_q[7:0];
    assign o_index_offset        = idx_q;
    assign o_extra_addr          = xptr_q;
    assign o_stack_addr          = stk_q;
    assign o_bank_select         = psw_reg[15:8];
    assign o_condition_flags     = psw_reg[7:0];

    // ==========================================================
    // Assertions
    // ==========================================================
    sequence s_write16(logic [11:0] off);
        i_avs_write && !o_avs_waitrequest && (i_avs_address == off) &&
        (i_avs_byteenable[1:0] == 2'h3);
    endsequence

    a_ip_reset_val: assert property (
        @(posedge i_ref_clk) $rose(i_reset_n) |-> (o_instruction_pointer == 16'hfffd))
        else $error("instruction pointer not fffd after reset");

    a_acc_low_byte: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_ACC) |=> (o_acc_byte == $past(i_avs_writedata[7:0])))
        else $error("accumulator low byte not updated");

    a_aux_low_byte: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_AUX) |=> (o_aux_byte == $past(i_avs_writedata[7:0])))
        else $error("auxiliary low byte not updated");

    a_index_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_IDX) |=> (o_index_offset == $past(i_avs_writedata[15:0])))
        else $error("index register not updated");

    a_extra_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_XPTR) |=> (o_extra_addr == $past(i_avs_writedata[15:0])))
        else $error("extra pointer not updated");

    a_stack_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_STK) |=> (o_stack_addr == $past(i_avs_writedata[15:0])))
        else $error("stack pointer not updated");

    a_bank_byte: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        s_write16(CPR_OFF_PSW) |=> (o_bank_select == $past(i_avs_writedata[15:8])) &&
                                   (o_condition_flags == $past(i_avs_writedata[7:0])))
        else $error("status word halves wrong");

    a_psw_reset_val: assert property (
        @(posedge i_ref_clk) $rose(i_reset_n) |->
        !o_condition_flags[7] && o_condition_flags[5] && o_condition_flags[4])
        else $error("status word reset bits wrong");

    a_gpr_readback: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        (i_gpr_we ##1 ($stable(i_gpr_sel) && $stable(o_bank_select)))
        |-> (o_gpr_rdata == $past(i_gpr_wdata)))
        else $error("general register readback wrong");

    a_bank_address: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_gpr_mem_addr == {o_bank_select[4:0], i_gpr_sel})
        else $error("general register address not in active bank");

    a_wait_bounded: assert property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("waitrequest held more than one cycle");

endmodule // cpr_regfile

// File: pkg/cpr_pkg.sv
// Constants for the banked CPU register file
package cpr_pkg;

    // ==========================================================
    // Bus geometry
    // ==========================================================
    localparam int          CPR_ADDR_W       = 12;
    localparam int          CPR_DATA_W       = 32;
    localparam int          CPR_BE_W         = 4;

    // ==========================================================
    // Dedicated register byte offsets
    // ==========================================================
    localparam logic [11:0] CPR_OFF_IP       = 12'h000;
    localparam logic [11:0] CPR_OFF_ACC      = 12'h004;
    localparam logic [11:0] CPR_OFF_AUX      = 12'h008;
    localparam logic [11:0] CPR_OFF_IDX      = 12'h00c;
    localparam logic [11:0] CPR_OFF_XPTR     = 12'h010;
    localparam logic [11:0] CPR_OFF_STK      = 12'h014;
    localparam logic [11:0] CPR_OFF_PSW      = 12'h018;
    localparam logic [11:0] CPR_OFF_BANKSEL  = 12'h01c;
    // General-purpose window: base + (bank*8 + reg)*4
    localparam logic [11:0] CPR_OFF_GPR_BASE = 12'h400;
    localparam logic [1:0]  CPR_GPR_REGION   = 2'h1;

    // ==========================================================
    // Register sizes and banking
    // ==========================================================
    localparam int          CPR_REG_W        = 16;
    localparam int          CPR_GPR_W        = 8;
    localparam int          CPR_REGS_PER_BANK = 8;
    localparam int          CPR_NUM_BANKS    = 32;
    localparam int          CPR_SEL_W        = 3;
    localparam int          CPR_BANK_W       = 5;

    // ==========================================================
    // Reset values and status word layout
    // ==========================================================
    localparam logic [15:0] CPR_IP_RESET     = 16'hfffd;
    localparam logic [15:0] CPR_PSW_RESET    = 16'h0030;
    localparam int          CPR_PSW_BANK_LSB = 8;
    localparam int          CPR_FLAG_TOP_BIT = 7;
    localparam int          CPR_LVL_HIGH_BIT = 5;
    localparam int          CPR_LVL_LOW_BIT  = 4;

    // Bus handshake states
    typedef enum logic [1:0] {
        CPR_ST_IDLE = 2'b01,
        CPR_ST_ACK  = 2'b10
    } cpr_bus_st_t;

endpackage

// File: rtl/cpr_reg16.sv
// Byte-writable 16-bit dedicated register with optional reset
`timescale 1ns/1ns
module cpr_reg16 #(
    parameter bit          HAS_RESET = 1'b0,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    // Write side
    input  wire logic        i_we,
    input  wire logic [1:0]  i_be,
    input  wire logic [15:0] i_wdata,
    // Stored value
    output logic      [15:0] o_q
);

    // ==========================================================
    // Storage
    // ==========================================================
    logic [15:0] q_reg;
    logic [15:0] q_next;

    // Merge enabled byte lanes
    assign q_next = {(i_we && i_be[1]) ? i_wdata[15:8] : q_reg[15:8],
                     (i_we && i_be[0]) ? i_wdata[7:0]  : q_reg[7:0]};

    // Data registers hold their value through reset unless asked
    always_ff @(posedge i_ref_clk) begin
        if (HAS_RESET && !i_reset_n) begin
            q_reg <= RESET_VAL;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;

endmodule // cpr_reg16

// File: rtl/cpr_gpr_bank.sv
// General-purpose register banks held in a data memory array
`timescale 1ns/1ns
module cpr_gpr_bank #(
    parameter int DEPTH  = 256,
    parameter int ADDR_W = 8
) (
    // Clock
    input  wire logic              i_ref_clk,
    // Write port
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [7:0]        i_wdata,
    // Two read ports
    input  wire logic [ADDR_W-1:0] i_raddr_a,
    input  wire logic [ADDR_W-1:0] i_raddr_b,
    output logic      [7:0]        o_rdata_a,
    output logic      [7:0]        o_rdata_b
);

    // ==========================================================
    // Memory array
    // ==========================================================
    logic [7:0] mem [DEPTH];

    // Single write port
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // Asynchronous reads
    assign o_rdata_a = mem[i_raddr_a];
    assign o_rdata_b = mem[i_raddr_b];

endmodule // cpr_gpr_bank

// File: verif/cpu_register_file_banked_bench.sv
// Self-checking bench for the banked CPU register file
`timescale 1ns/1ns
module cpu_register_file_banked_bench
    import cpr_pkg::*;
;
    // ==========================================================
    // Signals
    // ==========================================================
    logic                  clk;
    logic                  reset_n;
    logic [CPR_ADDR_W-1:0] avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [CPR_BE_W-1:0]   avs_byteenable;
    logic [CPR_DATA_W-1:0] avs_writedata;
    logic [CPR_DATA_W-1:0] avs_readdata;
    logic                  avs_waitrequest;
    logic [CPR_SEL_W-1:0]  gpr_sel;
    logic                  gpr_we;
    logic [7:0]            gpr_wdata;
    logic [7:0]            gpr_rdata;
    logic [7:0]            gpr_mem_addr;
    logic [15:0]           ip_q;
    logic [7:0]            acc_q;
    logic [7:0]            aux_q;
    logic [15:0]           index_q;
    logic [15:0]           extra_q;
    logic [15:0]           stack_q;
    logic [7:0]            bank_q;
    logic [7:0]            flags_q;
    logic [31:0]           rdv;
    logic [15:0]           vals [6];
    logic [11:0]           offs [6];
    int                    banks [3];
    int                    n_fail;
    int                    tests_run;

    // ==========================================================
    // Design under test
    // ==========================================================
    cpr_regfile DUT (
        .i_ref_clk             (clk),
        .i_reset_n             (reset_n),
        .i_avs_address         (avs_address),
        .i_avs_read            (avs_read),
        .i_avs_write           (avs_write),
        .i_avs_byteenable      (avs_byteenable),
        .i_avs_writedata       (avs_writedata),
        .o_avs_readdata        (avs_readdata),
        .o_avs_waitrequest     (avs_waitrequest),
        .i_gpr_sel             (gpr_sel),
        .i_gpr_we              (gpr_we),
        .i_gpr_wdata           (gpr_wdata),
        .o_gpr_rdata           (gpr_rdata),
        .o_gpr_mem_addr        (gpr_mem_addr),
        .o_instruction_pointer (ip_q),
        .o_acc_byte            (acc_q),
        .o_aux_byte            (aux_q),
        .o_index_offset        (index_q),
        .o_extra_addr          (extra_q),
        .o_stack_addr          (stack_q),
        .o_bank_select         (bank_q),
        .o_condition_flags     (flags_q)
    );

    // ==========================================================
    // Tasks
    // ==========================================================
    // Compare seen against expected and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One bus access, held until waitrequest is sampled low; a hang is left to the watchdog
    task automatic bus_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                            input logic [3:0] be);
        @(posedge clk);
        avs_address    <= addr;
        avs_read       <= ~wr;
        avs_write      <= wr;
        avs_byteenable <= be;
        avs_writedata  <= wdata;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Core write strobe of one general register
    task automatic core_wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge clk);
        gpr_sel   <= sel;
        gpr_we    <= 1'b1;
        gpr_wdata <= d;
        @(posedge clk);
        gpr_we    <= 1'b0;
    endtask

    // Select a general register and wait for settled outputs
    task automatic core_sel(input logic [2:0] sel);
        @(posedge clk);
        gpr_sel <= sel;
        @(negedge clk);
    endtask

    // Data pattern of one bank slot
    function automatic logic [7:0] gv(input int b, input int s);
        return 8'(b * 8 + s) ^ 8'h5a;
    endfunction

    // Print counts and verdict, then stop
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end

    // ==========================================================
    // Test sequence
    // ==========================================================
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_n = 1'b0;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0000_0000;
        gpr_sel = 3'h0;
        gpr_we = 1'b0;
        gpr_wdata = 8'h00;
        offs = '{CPR_OFF_IP, CPR_OFF_ACC, CPR_OFF_AUX, CPR_OFF_IDX, CPR_OFF_XPTR, CPR_OFF_STK};
        banks = '{0, 1, 31};
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values of pointer and status word
        @(negedge clk);
        check("ip reset", ip_q, 32'h0000_fffd);
        check("flag top reset", flags_q[7], 1'b0);
        check("level bits reset", flags_q[5:4], 2'b11);
        bus_xfer(1'b0, CPR_OFF_IP, 32'h0, 4'hf);
        check("ip bus reset", rdv, 32'h0000_fffd);
        // Full 16-bit write and readback of dedicated registers
        for (int i = 0; i < 6; i++) begin
            vals[i] = 16'ha5c3 ^ 16'(i * 16'h0f11);
            bus_xfer(1'b1, offs[i], {16'hdead, vals[i]}, 4'h3);
            bus_xfer(1'b0, offs[i], 32'h0, 4'hf);
            check("dedicated readback", rdv, {16'h0000, vals[i]});
        end
        @(negedge clk);
        check("ip view", ip_q, vals[0]);
        check("acc low byte", acc_q, vals[1][7:0]);
        check("aux low byte", aux_q, vals[2][7:0]);
        check("index offset", index_q, vals[3]);
        check("extra address", extra_q, vals[4]);
        check("stack address", stack_q, vals[5]);
        // Single-lane writes touch one byte only
        bus_xfer(1'b1, CPR_OFF_IDX, 32'h0000_7e11, 4'h2);
        bus_xfer(1'b1, CPR_OFF_ACC, 32'h0000_ff42, 4'h1);
        @(negedge clk);
        check("index high lane", index_q, {8'h7e, vals[3][7:0]});
        check("acc low lane", acc_q, 8'h42);
        // Status word halves
        bus_xfer(1'b1, CPR_OFF_PSW, 32'h0000_1ba5, 4'h3);
        @(negedge clk);
        check("bank half", bank_q, 8'h1b);
        check("flags half", flags_q, 8'ha5);
        bus_xfer(1'b0, CPR_OFF_BANKSEL, 32'h0, 4'hf);
        check("bank alias read", rdv, 32'h0000_001b);
        // Fill three banks from the core side
        foreach (banks[k]) begin
            bus_xfer(1'b1, CPR_OFF_BANKSEL, 32'(banks[k]), 4'h1);
            for (int s = 0; s < 8; s++) begin
                core_wr(3'(s), gv(banks[k], s));
                @(negedge clk);
                check("gpr memory address", gpr_mem_addr, {5'(banks[k]), 3'(s)});
            end
        end
        // Read every slot back through core and bus
        foreach (banks[k]) begin
            bus_xfer(1'b1, CPR_OFF_BANKSEL, 32'(banks[k]), 4'h1);
            for (int s = 0; s < 8; s++) begin
                core_sel(3'(s));
                check("gpr core read", gpr_rdata, gv(banks[k], s));
                bus_xfer(1'b0, CPR_OFF_GPR_BASE + 12'((banks[k] * 8 + s) * 4), 32'h0, 4'hf);
                check("gpr window read", rdv, {24'h0, gv(banks[k], s)});
            end
        end
        // Bus write into bank 31 slot 7, core sees it; upper select bits ignored
        bus_xfer(1'b1, CPR_OFF_GPR_BASE + 12'h3fc, 32'h0000_00c3, 4'h1);
        core_sel(3'h7);
        check("gpr window write", gpr_rdata, 8'hc3);
        bus_xfer(1'b1, CPR_OFF_BANKSEL, 32'h0000_00e1, 4'h1);
        core_sel(3'h3);
        check("bank low five bits", gpr_mem_addr, 8'h0b);
        check("bank one slot", gpr_rdata, gv(1, 3));
        // Unmapped places read zero
        bus_xfer(1'b1, 12'h020, 32'hffff_ffff, 4'hf);
        bus_xfer(1'b0, 12'h020, 32'h0, 4'hf);
        check("unmapped read", rdv, 32'h0000_0000);
        bus_xfer(1'b0, 12'h800, 32'h0, 4'hf);
        check("unmapped high read", rdv, 32'h0000_0000);
        // Second reset in mid-run
        bus_xfer(1'b1, CPR_OFF_PSW, 32'h0000_00c0, 4'h3);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        check("ip second reset", ip_q, 32'h0000_fffd);
        check("flag top second reset", flags_q[7], 1'b0);
        check("levels second reset", flags_q[5:4], 2'b11);
        test_done();
    end

endmodule // cpu_register_file_banked_bench
